// [rtl/cldt_top.sv]
// Purpose: Cascaded 8-bit event counter and 16-bit compare timer
// Assumes: Control bits are plain ports; pins are asynchronous and pass through two-stage synchronisers
// Notes: Board links compare A pin to the 8-bit external input
`timescale 1ns/1ps
module cldt_top
    import cldt_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] counter8_control_i,
    input wire cldt_ctrl_a_s counter16_control_a_i,
    input wire cldt_ctrl_b_s counter16_control_b_i,
    input wire logic [15:0] compare_a_value_i,
    input wire logic [15:0] compare_b_value_i,
    input wire logic counter8_wr_i,
    input wire logic [7:0] counter8_wdata_i,
    input wire logic counter16_wr_i,
    input wire logic [15:0] counter16_wdata_i,
    input wire cldt_flags_s timer_irq_mask_register_i,
    input wire cldt_flags_s flag_clear_i,
    input wire logic counter8_ext_input_i,
    input wire logic counter16_ext_input_i,
    input wire logic capture_input_i,
    output logic [7:0] counter8_value_o,
    output logic [15:0] counter16_value_o,
    output logic [15:0] capture_value_o,
    output cldt_flags_s timer_flag_register_o,
    output logic timer_irq_o,
    output logic compare_a_output_pin_o,
    output logic compare_a_output_oe_o,
    output logic compare_b_output_pin_o,
    output logic compare_b_output_oe_o
);
    // Prescaler taps shared by both counters
    cldt_taps_s taps;

    // Synchronised edges of the three input pins
    logic ext8_rise;
    logic ext8_fall;
    logic ext16_rise;
    logic ext16_fall;
    logic cap_rise;
    logic cap_fall;

    // Registered state
    logic [7:0] cnt8_ff; // 8-bit count
    logic [15:0] cnt16_ff; // 16-bit count
    logic [15:0] cap_ff; // Captured count
    cldt_flags_s flags_ff; // Sticky event flags
    logic irq_ff; // Masked interrupt
    logic oca_ff; // Compare A pin level
    logic ocb_ff; // Compare B pin level
    logic oea_ff; // Compare A pin enable
    logic oeb_ff; // Compare B pin enable

    // Next values
    logic [7:0] nxt_cnt8;
    logic [15:0] nxt_cnt16;
    logic [15:0] nxt_cap;
    cldt_flags_s nxt_flags;
    logic nxt_irq;
    logic nxt_oca;
    logic nxt_ocb;

    // Decoded events
    logic tick8; // 8-bit count enable
    logic tick16; // 16-bit count enable
    logic [7:0] inc8; // 8-bit count plus one
    logic [15:0] inc16; // 16-bit count plus one
    logic ovf8_evt; // 8-bit wraps
    logic ovf16_evt; // 16-bit wraps
    logic match_a; // Channel A match
    logic match_b; // Channel B match
    logic clear16; // Clear on channel A match
    logic cap_evt; // Selected capture edge
    cldt_flags_s set_flags; // Events this cycle

    // One shared divider
    cldt_prescaler u_prescaler (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .taps_o(taps)
    );

    // Counter 8 external input
    cldt_edge_sync u_sync_ext8 (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(counter8_ext_input_i),
        .rise_o(ext8_rise),
        .fall_o(ext8_fall)
    );

    // Counter 16 external input
    cldt_edge_sync u_sync_ext16 (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(counter16_ext_input_i),
        .rise_o(ext16_rise),
        .fall_o(ext16_fall)
    );

    // Capture input
    cldt_edge_sync u_sync_cap (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(capture_input_i),
        .rise_o(cap_rise),
        .fall_o(cap_fall)
    );

    // Each counter picks its own source
    assign tick8 = sel_tick(counter8_control_i, taps, ext8_rise, ext8_fall);
    assign tick16 = sel_tick(counter16_control_b_i.clk_sel, taps, ext16_rise,
                             ext16_fall);

    // Increments
    assign inc8 = cnt8_ff + 8'h01;
    assign inc16 = cnt16_ff + 16'h0001;

    // Overflow when a tick meets the top value; a write cancels the tick
    assign ovf8_evt = tick8 && (cnt8_ff == `CLDT_CNT8_MAX) && !counter8_wr_i;
    assign ovf16_evt = tick16 && (cnt16_ff == `CLDT_CNT16_MAX) && !counter16_wr_i;

    // Match when the count steps onto the compare value
    assign match_a = tick16 && (inc16 == compare_a_value_i) && !counter16_wr_i;
    assign match_b = tick16 && (inc16 == compare_b_value_i) && !counter16_wr_i;
    // Clearing on that step gives a period of exactly the compare value
    assign clear16 = match_a && counter16_control_b_i.clear_on_match;

    // Capture edge polarity
    assign cap_evt = counter16_control_b_i.capture_rising ? cap_rise : cap_fall;

    // Event set vector
    assign set_flags.ovf8 = ovf8_evt;
    assign set_flags.ovf16 = ovf16_evt;
    assign set_flags.compare_a = match_a;
    assign set_flags.compare_b = match_b;
    assign set_flags.capture = cap_evt;

    // Next 8-bit count: write, then tick, else hold
    assign nxt_cnt8 = counter8_wr_i ? counter8_wdata_i :
                      (tick8 ? inc8 : cnt8_ff);

    // Next 16-bit count: write, then clear, then tick, else hold
    assign nxt_cnt16 = counter16_wr_i ? counter16_wdata_i :
                       (clear16 ? `CLDT_CNT16_RST :
                       (tick16 ? inc16 : cnt16_ff));

    // Capture latches the current count
    assign nxt_cap = cap_evt ? cnt16_ff : cap_ff;

    // Set wins over a clear in the same cycle
    assign nxt_flags = (flags_ff & ~flag_clear_i) | set_flags;

    // Interrupt follows the masked flags
    assign nxt_irq = |(nxt_flags & timer_irq_mask_register_i);

    // Pin actions on each match
    assign nxt_oca = pin_next(counter16_control_a_i.act_a, match_a, oca_ff);
    assign nxt_ocb = pin_next(counter16_control_a_i.act_b, match_b, ocb_ff);

    // Counters
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt8_ff <= `CLDT_CNT8_RST;
            cnt16_ff <= `CLDT_CNT16_RST;
            cap_ff <= `CLDT_CNT16_RST;
        end else begin
            cnt8_ff <= nxt_cnt8;
            cnt16_ff <= nxt_cnt16;
            cap_ff <= nxt_cap;
        end
    end

    // Flags and interrupt
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flags_ff <= `CLDT_FLAGS_RST;
            irq_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            irq_ff <= nxt_irq;
        end
    end

    // Compare pins and their enables
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            oca_ff <= 1'b0;
            ocb_ff <= 1'b0;
            oea_ff <= 1'b0;
            oeb_ff <= 1'b0;
        end else begin
            oca_ff <= nxt_oca;
            ocb_ff <= nxt_ocb;
            oea_ff <= counter16_control_a_i.act_a != ACT_NONE;
            oeb_ff <= counter16_control_a_i.act_b != ACT_NONE;
        end
    end

    // Outputs straight from flops
    assign counter8_value_o = cnt8_ff;
    assign counter16_value_o = cnt16_ff;
    assign capture_value_o = cap_ff;
    assign timer_flag_register_o = flags_ff;
    assign timer_irq_o = irq_ff;
    assign compare_a_output_pin_o = oca_ff;
    assign compare_a_output_oe_o = oea_ff;
    assign compare_b_output_pin_o = ocb_ff;
    assign compare_b_output_oe_o = oeb_ff;

    // Checks

    // Divide-by-8 tap recurs every eight cycles
    tap8_period_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        taps.d8 |=> !taps.d8 [*7] ##1 taps.d8)
        else $error("divide by 8 tap period wrong");

    // Stopped counter holds its value
    stop_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (counter8_control_i == `CLDT_CS_STOP && !counter8_wr_i) |=> $stable(cnt8_ff))
        else $error("stopped counter moved");

    // Pin edge reaches the counter two cycles later
    ext_sync_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ($rose(counter8_ext_input_i) && $past(rst_i) == 1'b0) |-> ##2 ext8_rise)
        else $error("external edge not seen after sync");

    // External rising edge adds one
    ext_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (counter8_control_i == `CLDT_CS_EXT_RISE && ext8_rise && !counter8_wr_i)
        |=> cnt8_ff == $past(inc8))
        else $error("external edge did not increment");

    // Overflow of the 8-bit counter sets its flag and wraps
    ovf8_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ovf8_evt |=> (flags_ff.ovf8 && cnt8_ff == `CLDT_CNT8_RST))
        else $error("8-bit overflow flag missing");

    // Interrupt only with an enabled flag
    irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        timer_irq_o |-> |(flags_ff & $past(timer_irq_mask_register_i)))
        else $error("interrupt without enabled flag");

    // Overflow of the 16-bit counter sets its flag
    ovf16_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ovf16_evt |=> flags_ff.ovf16)
        else $error("16-bit overflow flag missing");

    // Channel B match sets its flag
    match_b_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (tick16 && inc16 == compare_b_value_i && !counter16_wr_i) |=> flags_ff.compare_b)
        else $error("channel B match flag missing");

    // Clear on match reloads zero
    clear_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clear16 |=> cnt16_ff == `CLDT_CNT16_RST)
        else $error("counter not cleared on match");

    // Toggle mode inverts the pin on match
    toggle_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (match_a && counter16_control_a_i.act_a == ACT_TOGGLE)
        |=> compare_a_output_pin_o != $past(compare_a_output_pin_o))
        else $error("compare A pin did not toggle");

    // Divided taps nest: the slowest tap implies all faster ones
    tap_nest_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        taps.d1024
        |-> (taps.d256 && taps.d64 && taps.d8))
        else $error("prescaler taps out of step");

    // Stopped 16-bit counter holds its value
    stop16_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (counter16_control_b_i.clk_sel == `CLDT_CS_STOP && !counter16_wr_i)
        |=> $stable(cnt16_ff))
        else $error("stopped 16-bit counter moved");

    // A write loads the 8-bit count whatever the source
    write8_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        counter8_wr_i
        |=> cnt8_ff == $past(counter8_wdata_i))
        else $error("8-bit write lost");

    // A write loads the 16-bit count whatever the source
    write16_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        counter16_wr_i
        |=> cnt16_ff == $past(counter16_wdata_i))
        else $error("16-bit write lost");

    // Overflow of the 16-bit counter wraps to zero
    wrap16_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ovf16_evt
        |=> cnt16_ff == `CLDT_CNT16_RST)
        else $error("16-bit counter did not wrap");

    // Channel A match sets its flag
    match_a_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        match_a
        |=> flags_ff.compare_a)
        else $error("channel A match flag missing");

    // Capture edge latches the count and sets its flag
    capture_latch_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cap_evt
        |=> (capture_value_o == $past(cnt16_ff) && flags_ff.capture))
        else $error("capture not latched");

    // 8-bit overflow flag stays set until cleared
    flag_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (flags_ff.ovf8 && !flag_clear_i.ovf8)
        |=> flags_ff.ovf8)
        else $error("overflow flag dropped without clear");

    // An enabled flag that is not being cleared raises the interrupt
    irq_raise_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (|(flags_ff & ~flag_clear_i & timer_irq_mask_register_i))
        |=> timer_irq_o)
        else $error("enabled flag raised no interrupt");

    // A counting tick without write or clear steps up by one
    count16_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (tick16 && !counter16_wr_i && !clear16)
        |=> cnt16_ff == $past(inc16))
        else $error("16-bit counter did not step");

    // Compare A pin moves only on a channel A match
    pin_a_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !match_a
        |=> $stable(compare_a_output_pin_o))
        else $error("compare A pin moved without match");

    // 16-bit external pin edge is seen two cycles later
    ext16_sync_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ($rose(counter16_ext_input_i) && $past(rst_i) == 1'b0)
        |-> ##2 ext16_rise)
        else $error("16-bit external edge not seen after sync");

    // Main scenarios
    ovf8_seen_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        ovf8_evt && counter8_control_i == `CLDT_CS_EXT_RISE);
    clear_seen_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        clear16 && counter16_control_a_i.act_a == ACT_TOGGLE);
    capture_seen_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) cap_evt);
    irq_seen_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(timer_irq_o));
    ovf16_seen_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) ovf16_evt);
endmodule // cldt_top

// [rtl/cldt_defines.svh]
// Purpose: Shared constants for the cascaded long delay timers
// Assumes: One clock, synchronous active-high reset
// Notes: Clock select codes are common to both counters
`ifndef CLDT_DEFINES_SVH
`define CLDT_DEFINES_SVH

// Clock select codes
`define CLDT_CS_STOP 3'h0
`define CLDT_CS_CK 3'h1
`define CLDT_CS_DIV8 3'h2
`define CLDT_CS_DIV64 3'h3
`define CLDT_CS_DIV256 3'h4
`define CLDT_CS_DIV1024 3'h5
`define CLDT_CS_EXT_RISE 3'h6
`define CLDT_CS_EXT_FALL 3'h7

// Prescaler width, reset and tap masks
`define CLDT_PRE_RST 10'h000
`define CLDT_TAP8_MASK 10'h007
`define CLDT_TAP64_MASK 10'h03f
`define CLDT_TAP256_MASK 10'h0ff
`define CLDT_TAP1024_MASK 10'h3ff

// Counter reset values and limits
`define CLDT_CNT8_RST 8'h00
`define CLDT_CNT8_MAX 8'hff
`define CLDT_CNT16_RST 16'h0000
`define CLDT_CNT16_MAX 16'hffff
`define CLDT_FLAGS_RST 5'h00

`endif

// [rtl/cldt_pkg.sv]
// Purpose: Types and shared helpers for the cascaded long delay timers
// Assumes: cldt_defines.svh supplies the codes
// Notes: sel_tick is used by both counters; pin_next only by the compare pins
package cldt_pkg;
`include "cldt_defines.svh"

    // Compare pin action on a match
    typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} cldt_action_e;

    // Interrupt flags and masks share this layout
    typedef struct packed {
        logic capture;
        logic compare_b;
        logic compare_a;
        logic ovf16;
        logic ovf8;
    } cldt_flags_s;

    // First control of the 16-bit counter: pin actions
    typedef struct packed {
        cldt_action_e act_a;
        cldt_action_e act_b;
    } cldt_ctrl_a_s;

    // Second control of the 16-bit counter
    typedef struct packed {
        logic capture_rising;
        logic clear_on_match;
        logic [2:0] clk_sel;
    } cldt_ctrl_b_s;

    // Prescaler tap pulses
    typedef struct packed {
        logic d1024;
        logic d256;
        logic d64;
        logic d8;
    } cldt_taps_s;

    // Count enable chosen by a clock select code
    function automatic logic sel_tick(input logic [2:0] sel, input cldt_taps_s taps,
                                      input logic rise, input logic fall);
        logic t;
        t = 1'b0;
        case (sel)
            `CLDT_CS_STOP: t = 1'b0;
            `CLDT_CS_CK: t = 1'b1;
            `CLDT_CS_DIV8: t = taps.d8;
            `CLDT_CS_DIV64: t = taps.d64;
            `CLDT_CS_DIV256: t = taps.d256;
            `CLDT_CS_DIV1024: t = taps.d1024;
            `CLDT_CS_EXT_RISE: t = rise;
            `CLDT_CS_EXT_FALL: t = fall;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // Next compare pin level
    function automatic logic pin_next(input cldt_action_e act, input logic match,
                                      input logic cur);
        logic p;
        p = cur;
        if (match) begin
            case (act)
                ACT_TOGGLE: p = ~cur;
                ACT_CLEAR: p = 1'b0;
                ACT_SET: p = 1'b1;
                default: p = cur;
            endcase
        end
        return p;
    endfunction
endpackage

// [rtl/cldt_prescaler.sv]
// Purpose: Free running 10-bit prescaler with four divided taps
// Assumes: Runs on every rising clock edge
// Notes: Taps are one-cycle pulses
`timescale 1ns/1ps
module cldt_prescaler
    import cldt_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    output cldt_taps_s taps_o
);
    logic [9:0] pre_ff; // Shared divider count
    logic [9:0] nxt_pre;

    assign nxt_pre = pre_ff + 10'h001;
    // Each tap fires when its low bits are all ones
    assign taps_o.d8 = (pre_ff & `CLDT_TAP8_MASK) == `CLDT_TAP8_MASK;
    assign taps_o.d64 = (pre_ff & `CLDT_TAP64_MASK) == `CLDT_TAP64_MASK;
    assign taps_o.d256 = (pre_ff & `CLDT_TAP256_MASK) == `CLDT_TAP256_MASK;
    assign taps_o.d1024 = (pre_ff & `CLDT_TAP1024_MASK) == `CLDT_TAP1024_MASK;

    // Divider advances every cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pre_ff <= `CLDT_PRE_RST;
        end else begin
            pre_ff <= nxt_pre;
        end
    end
endmodule // cldt_prescaler

// [rtl/cldt_edge_sync.sv]
// Purpose: Two-stage synchroniser with edge pulses
// Assumes: Pin changes no faster than one clock period
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module cldt_edge_sync (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);
    logic meta_ff; // First stage
    logic sync_ff; // Second stage
    logic last_ff; // Previous synchronised level

    // Edges seen after synchronisation
    assign rise_o = sync_ff & ~last_ff;
    assign fall_o = ~sync_ff & last_ff;

    // Sample on each rising clock edge
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end
endmodule // cldt_edge_sync

// [tb/cldt_pulse_src.sv]
// Purpose: Model of the external count source on the 8-bit count pin
// Assumes: Caller enters burst just after a falling clock edge
// Notes: Levels change only on falling edges, so the design sees clean samples
`timescale 1ns/1ps
module cldt_pulse_src (
    input wire logic ref_clk_i,
    output logic pin_o
);
    // Pin rests low between bursts
    initial pin_o = 1'b0;

    // Emit n rising edges, each level held for half clock periods
    task automatic burst(input int n, input int half);
        for (int i = 0; i < n; i++) begin
            pin_o = 1'b1;
            repeat (half) @(negedge ref_clk_i);
            pin_o = 1'b0;
            repeat (half) @(negedge ref_clk_i);
        end
    endtask
endmodule // cldt_pulse_src

// [tb/tb_cldt_top.sv]
// Purpose: Self-checking bench for the cascaded long delay timers
// Assumes: Inputs change at falling edges; 20 MHz clock
// Notes: A link select stands in for the board wire from compare pin A
`timescale 1ns/1ps
module tb_cldt_top
    import cldt_pkg::*;
;
`include "cldt_defines.svh"
    logic ref_clk_i = 1'b0; // System clock
    logic rst_i = 1'b1; // Synchronous reset
    logic [2:0] sel8 = 3'h0; // 8-bit clock select
    cldt_ctrl_a_s ctrl_a = '0; // Pin actions
    cldt_ctrl_b_s ctrl_b = '0; // 16-bit control
    logic [15:0] cmp_a = 16'h0000;
    logic [15:0] cmp_b = 16'h0000;
    logic wr8 = 1'b0;
    logic [7:0] wd8 = 8'h00;
    logic wr16 = 1'b0;
    logic [15:0] wd16 = 16'h0000;
    cldt_flags_s mask = '0; // Interrupt enables
    cldt_flags_s fclr = '0; // Flag clear strobes
    logic link = 1'b0; // High: compare pin A drives the 8-bit pin
    logic src_pin; // Partner pin
    logic ext16 = 1'b0; // 16-bit external pin
    logic cap_pin = 1'b0; // Capture pin
    logic [15:0] cap_val; // Captured count
    logic [7:0] cnt8;
    logic [15:0] cnt16;
    cldt_flags_s flags;
    logic irq, pin_a, oe_a, pin_b, oe_b;
    int err_total = 0;
    int num_checks = 0;

    // Free running clock, 50 ns period
    always #25 ref_clk_i = ~ref_clk_i;

    cldt_pulse_src src (.ref_clk_i(ref_clk_i), .pin_o(src_pin));

    cldt_top dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .counter8_control_i(sel8),
        .counter16_control_a_i(ctrl_a), .counter16_control_b_i(ctrl_b),
        .compare_a_value_i(cmp_a), .compare_b_value_i(cmp_b),
        .counter8_wr_i(wr8), .counter8_wdata_i(wd8),
        .counter16_wr_i(wr16), .counter16_wdata_i(wd16),
        .timer_irq_mask_register_i(mask), .flag_clear_i(fclr),
        .counter8_ext_input_i(link ? pin_a : src_pin),
        .counter16_ext_input_i(ext16), .capture_input_i(cap_pin),
        .counter8_value_o(cnt8), .counter16_value_o(cnt16), .capture_value_o(cap_val),
        .timer_flag_register_o(flags), .timer_irq_o(irq),
        .compare_a_output_pin_o(pin_a), .compare_a_output_oe_o(oe_a),
        .compare_b_output_pin_o(pin_b), .compare_b_output_oe_o(oe_b)
    );

    // Wait n falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // Compare one value and count the result
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask

    // Reset pulse of n cycles, then release
    task automatic do_reset(input int n);
        rst_i = 1'b1;
        tick(n);
        rst_i = 1'b0;
    endtask

    // Load both counts with one-cycle write strobes
    task automatic load(input logic [7:0] v8, input logic [15:0] v16);
        wd8 = v8;
        wd16 = v16;
        wr8 = 1'b1;
        wr16 = 1'b1;
        tick(1);
        wr8 = 1'b0;
        wr16 = 1'b0;
    endtask

    // Clear every flag
    task automatic clear_all();
        fclr = '1;
        tick(1);
        fclr = '0;
        tick(1);
    endtask

    // Outputs after reset
    task automatic t_reset();
        chk("count8", 16'h0000, {8'h00, cnt8});
        chk("count16", 16'h0000, cnt16);
        chk("flags", 16'h0000, {11'h000, flags});
        chk("pins", 16'h0000, {11'h000, irq, pin_a, oe_a, pin_b, oe_b});
    endtask

    // Every internal clock source of the 16-bit counter, then stop
    task automatic t_select();
        int ratio[5] = '{1, 8, 64, 256, 1024};
        logic [15:0] c0;
        for (int i = 0; i < 5; i++) begin
            ctrl_b.clk_sel = 3'(i + 1);
            tick(1);
            c0 = cnt16;
            tick(2 * ratio[i]);
            chk("ticks", 16'h0002, cnt16 - c0);
        end
        ctrl_b.clk_sel = `CLDT_CS_STOP;
        load(8'h00, 16'h1234);
        tick(40);
        chk("stopped", 16'h1234, cnt16);
    endtask

    // External counting on both edge codes, overflow, mask, clear
    task automatic t_ext8();
        for (int e = 6; e < 8; e++) begin
            sel8 = 3'(e);
            load(8'h00, 16'h1234);
            src.burst(5, 1);
            tick(4);
            chk("ext count", 16'h0005, {8'h00, cnt8});
        end
        sel8 = `CLDT_CS_EXT_RISE;
        load(8'hfd, 16'h1234);
        src.burst(3, 2);
        tick(4);
        chk("wrap8", 16'h0000, {8'h00, cnt8});
        chk("ovf8 flag", 16'h0001, {15'h0000, flags.ovf8});
        chk("irq masked", 16'h0000, {15'h0000, irq});
        mask.ovf8 = 1'b1;
        tick(2);
        chk("irq on", 16'h0001, {15'h0000, irq});
        clear_all();
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        mask = '0;
    endtask

    // Compare A toggles and clears, compare B sets its pin
    task automatic t_compare();
        int tog;
        logic last;
        sel8 = `CLDT_CS_STOP;
        ctrl_a = '{act_a: ACT_TOGGLE, act_b: ACT_SET};
        cmp_a = 16'h0003;
        cmp_b = 16'h0002;
        mask.compare_a = 1'b1;
        ctrl_b = '{capture_rising: 1'b0, clear_on_match: 1'b1, clk_sel: `CLDT_CS_CK};
        load(8'h00, 16'h0000);
        tick(3);
        tog = 0;
        last = pin_a;
        for (int i = 0; i < 30; i++) begin
            tick(1);
            if (cnt16 > 16'h0002) chk("count16 max", 16'h0002, cnt16);
            if (pin_a !== last) tog++;
            last = pin_a;
        end
        chk("toggles", 16'h000a, 16'(tog));
        chk("pin b", 16'h0001, {15'h0000, pin_b});
        chk("oe", 16'h0003, {14'h0000, oe_a, oe_b});
        chk("cmp flags", 16'h0003, {14'h0000, flags.compare_b, flags.compare_a});
        chk("cmp irq", 16'h0001, {15'h0000, irq});
        ctrl_b.clk_sel = `CLDT_CS_STOP;
        mask = '0;
    endtask

    // 16-bit external source through wrap, compare B clear, capture
    task automatic t_misc();
        ctrl_a = '{act_a: ACT_NONE, act_b: ACT_CLEAR};
        cmp_b = 16'h0001;
        ctrl_b = '{capture_rising: 1'b1, clear_on_match: 1'b0, clk_sel: `CLDT_CS_EXT_RISE};
        load(8'h00, 16'hfffe);
        clear_all();
        for (int i = 0; i < 3; i++) begin
            ext16 = 1'b1;
            tick(1);
            ext16 = 1'b0;
            tick(1);
        end
        tick(3);
        chk("ext16 count", 16'h0001, cnt16);
        chk("ovf16 cmp b", 16'h0003, {14'h0000, flags.ovf16, flags.compare_b});
        chk("pin b clear", 16'h0000, {15'h0000, pin_b});
        cap_pin = 1'b1;
        tick(4);
        chk("capture", 16'h0001, cap_val);
        chk("cap flag", 16'h0001, {15'h0000, flags.capture});
        cap_pin = 1'b0;
        ctrl_b.clk_sel = `CLDT_CS_STOP;
    endtask

    // Cascade through the board link; first rising edge of the pin is match one
    task automatic t_cascade();
        localparam int RATIO = 8;
        localparam int CMP = 3;
        localparam int START = 254;
        localparam int NOM = (2 * (256 - START) - 1) * RATIO * CMP;
        localparam int SYNC = 3; // Pin edge to count takes three cycles
        int cyc;
        do_reset(2);
        t_reset();
        link = 1'b1;
        mask.ovf8 = 1'b1;
        ctrl_a = '{act_a: ACT_TOGGLE, act_b: ACT_NONE};
        cmp_a = 16'(CMP);
        sel8 = `CLDT_CS_EXT_RISE;
        ctrl_b = '{capture_rising: 1'b0, clear_on_match: 1'b1, clk_sel: `CLDT_CS_DIV8};
        load(8'(START), 16'h0000);
        cyc = 1;
        while (flags.ovf8 !== 1'b1 && cyc < 200) begin
            tick(1);
            cyc++;
        end
        chk("delay", 16'(NOM + SYNC), 16'(cyc));
        chk("cascade wrap", 16'h0000, {8'h00, cnt8});
        tick(2);
        chk("cascade irq", 16'h0001, {15'h0000, irq});
        link = 1'b0;
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        tick(20);
        rst_i = 1'b0;
        t_reset();
        t_select();
        t_ext8();
        t_compare();
        t_misc();
        t_cascade();
        close_out();
    end

    // Watchdog well beyond the expected run of about 3000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        close_out();
    end
endmodule // tb_cldt_top
